//--- logic/trim_regs_pkg.sv
package trim_regs_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 10;
    localparam int DATA_W = 16;
    localparam int LANE_COUNT = 8;
    localparam int TRIM_W = 12;

    typedef logic [TRIM_W-1:0] trim_t;
    typedef logic [LANE_COUNT-1:0] lane_mask_t;

    // ------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] LANE_ALARM_ADDR = 10'h2c4;
    localparam logic [ADDR_W-1:0] CORE0_TRIM_ADDR = 10'h330;
    localparam logic [ADDR_W-1:0] CORE1_TRIM_ADDR = 10'h332;
    localparam logic [ADDR_W-1:0] CORE2A_TRIM_ADDR = 10'h334;
    localparam logic [ADDR_W-1:0] CORE2B_TRIM_ADDR = 10'h336;

    // ------------------------------------------------------------
    // reset values and fixed patterns
    // ------------------------------------------------------------
    localparam lane_mask_t LANE_ALARM_RESET = 8'hff;
    localparam lane_mask_t LANE_NONE = 8'h00;
    localparam trim_t TRIM_RESET = 12'h000;
    localparam logic [DATA_W-1:0] READ_IDLE = 16'h0000;

    // ------------------------------------------------------------
    // calibration engine trim select codes
    // ------------------------------------------------------------
    localparam logic [1:0] CAL_SEL_CORE0 = 2'h0;
    localparam logic [1:0] CAL_SEL_CORE1 = 2'h1;
    localparam logic [1:0] CAL_SEL_CORE2A = 2'h2;
    localparam logic [1:0] CAL_SEL_CORE2B = 2'h3;

endpackage

//--- logic/core_sample_if.sv
`timescale 1ns/10ps
`default_nettype none
interface core_sample_if #(
    parameter int W = 12
) (
    input wire logic clk,
    input wire logic rst
);
    logic [W-1:0] sample;
    logic sample_valid;
    logic [W-1:0] trim;
    logic [W-1:0] result;
    logic result_valid;

    modport source (
        input clk, rst, result, result_valid,
        output sample, sample_valid, trim
    );
    modport apply (
        input clk, rst, sample, sample_valid, trim,
        output result, result_valid
    );
endinterface
`default_nettype wire

//--- logic/lane_alarm.sv
`timescale 1ns/10ps
`default_nettype none
module lane_alarm
    import trim_regs_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [LANES-1:0] lane_error_in,
    input wire logic [LANES-1:0] clear_in,
    output logic [LANES-1:0] alarm_out
);
    logic [LANES-1:0] alarm_reg;
    logic [LANES-1:0] alarm_next;

    // ------------------------------------------------------------
    // sticky lane flags
    // ------------------------------------------------------------
    // set beats clear
    assign alarm_next = (alarm_reg & ~clear_in) | lane_error_in;

    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_reg <= LANES'(LANE_ALARM_RESET);
        end else begin
            alarm_reg <= alarm_next;
        end
    end

    assign alarm_out = alarm_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_alarm_reset_ones:
    assert property (@(posedge clk) $fell(rst) |-> alarm_out == '1)
        else $error("lane alarms not all set after reset");
    a_alarm_error_sets:
    assert property (lane_error_in[0] |=> alarm_out[0])
        else $error("lane error did not set its alarm");
    a_alarm_one_clears:
    assert property (clear_in[1] && !lane_error_in[1] |=> !alarm_out[1])
        else $error("write of one did not clear lane alarm");
    a_alarm_zero_keeps:
    assert property (!clear_in[2] && !lane_error_in[2]
                     |=> alarm_out[2] == $past(alarm_out[2]))
        else $error("lane alarm changed without cause");
    a_alarm_set_wins:
    assert property (clear_in[3] && lane_error_in[3] |=> alarm_out[3])
        else $error("clear beat a simultaneous lane error");
endmodule
`default_nettype wire

//--- logic/offset_apply.sv
`timescale 1ns/10ps
`default_nettype none
module offset_apply (
    core_sample_if.apply port
);
    logic [$bits(port.sample)-1:0] result_reg;
    logic valid_reg;
    logic [$bits(port.sample)-1:0] result_next;

    // ------------------------------------------------------------
    // unsigned offset removal
    // ------------------------------------------------------------
    // saturate at zero so a large trim cannot wrap a sample to full scale
    assign result_next = (port.sample >= port.trim) ?
                         port.sample - port.trim : '0;

    always_ff @(posedge port.clk) begin
        if (port.rst) begin
            result_reg <= '0;
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= port.sample_valid;
            if (port.sample_valid) begin
                result_reg <= result_next;
            end
        end
    end

    assign port.result = result_reg;
    assign port.result_valid = valid_reg;

    a_apply_trim_math:
    assert property (@(posedge port.clk) disable iff (port.rst)
        port.sample_valid && port.sample >= port.trim
        |=> port.result_valid
            && port.result == $past(port.sample) - $past(port.trim))
        else $error("trimmed sample wrong");
endmodule
`default_nettype wire

//--- logic/lane_alarm_offset_trim_regs.sv
// How it works
// - eight lane alarms, set on buffer slip
// - lane alarms read all ones after reset
// - writing one clears a lane alarm
// - persisting slip sets the alarm again
// - summary clear wipes all lane alarms except lanes slipping in that cycle
// - core 0 twelve bit trim applied
// - core 1 own trim applied
// - core 2 trim follows selected input
// - second trim only for second input
// - trims load from fuse storage
// - spare cores still offset calibrated
// - masked summary alarm stays out
`timescale 1ns/10ps
`default_nettype none
module lane_alarm_offset_trim_regs
    import trim_regs_pkg::*;
#(
    parameter int LANES = LANE_COUNT
) (
    // clock and reset
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    // register port
    input wire logic [ADDR_W-1:0] ADDR_IN,
    input wire logic [DATA_W-1:0] WR_DATA_IN,
    input wire logic WR_STROBE_IN,
    input wire logic RD_STROBE_IN,
    output logic [DATA_W-1:0] RD_DATA_OUT,
    // lane buffer status and summary alarm
    input wire logic [LANES-1:0] LANE_BUFFER_ERROR_IN,
    input wire logic SUMMARY_ALARM_CLEAR_IN,
    input wire logic SUMMARY_ALARM_MASK_IN,
    output logic SUMMARY_ALARM_OUT,
    output logic SUMMARY_ALARM_CONTRIB_OUT,
    // fuse storage
    input wire logic FUSE_LOAD_IN,
    input wire logic [TRIM_W-1:0] FUSE_CORE0_IN,
    input wire logic [TRIM_W-1:0] FUSE_CORE1_IN,
    input wire logic [TRIM_W-1:0] FUSE_CORE2A_IN,
    input wire logic [TRIM_W-1:0] FUSE_CORE2B_IN,
    // calibration engine
    input wire logic CAL_TRIM_WRITE_IN,
    input wire logic [1:0] CAL_TRIM_SEL_IN,
    input wire logic [TRIM_W-1:0] CAL_TRIM_DATA_IN,
    // converter core samples
    input wire logic [TRIM_W-1:0] CORE0_SAMPLE_IN,
    input wire logic CORE0_VALID_IN,
    input wire logic [TRIM_W-1:0] CORE1_SAMPLE_IN,
    input wire logic CORE1_VALID_IN,
    input wire logic [TRIM_W-1:0] CORE2_SAMPLE_IN,
    input wire logic CORE2_VALID_IN,
    input wire logic CORE2_SECOND_INPUT_IN,
    // trimmed samples
    output logic [TRIM_W-1:0] CORE0_RESULT_OUT,
    output logic CORE0_RESULT_VALID_OUT,
    output logic [TRIM_W-1:0] CORE1_RESULT_OUT,
    output logic CORE1_RESULT_VALID_OUT,
    output logic [TRIM_W-1:0] CORE2_RESULT_OUT,
    output logic CORE2_RESULT_VALID_OUT
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic hit_alarm;
    wire logic hit_core0;
    wire logic hit_core1;
    wire logic hit_core2a;
    wire logic hit_core2b;
    wire logic wr_alarm;
    wire logic wr_core0;
    wire logic wr_core1;
    wire logic wr_core2a;
    wire logic wr_core2b;

    assign hit_alarm = ADDR_IN == LANE_ALARM_ADDR;
    assign hit_core0 = ADDR_IN == CORE0_TRIM_ADDR;
    assign hit_core1 = ADDR_IN == CORE1_TRIM_ADDR;
    assign hit_core2a = ADDR_IN == CORE2A_TRIM_ADDR;
    assign hit_core2b = ADDR_IN == CORE2B_TRIM_ADDR;
    assign wr_alarm = WR_STROBE_IN && hit_alarm;
    assign wr_core0 = WR_STROBE_IN && hit_core0;
    assign wr_core1 = WR_STROBE_IN && hit_core1;
    assign wr_core2a = WR_STROBE_IN && hit_core2a;
    assign wr_core2b = WR_STROBE_IN && hit_core2b;

    // ------------------------------------------------------------
    // lane buffer alarms
    // ------------------------------------------------------------
    wire logic [LANES-1:0] lane_clear;
    wire logic [LANES-1:0] lane_alarm;

    assign lane_clear =
        (wr_alarm ? WR_DATA_IN[LANES-1:0] : LANES'(LANE_NONE)) |
        (SUMMARY_ALARM_CLEAR_IN ? LANES'(LANE_ALARM_RESET)
                                : LANES'(LANE_NONE));

    lane_alarm #(
        .LANES(LANES)
    ) alarm_bits (
        .clk(CLK_SYS_IN),
        .rst(RESET_IN),
        .lane_error_in(LANE_BUFFER_ERROR_IN),
        .clear_in(lane_clear),
        .alarm_out(lane_alarm)
    );

    assign SUMMARY_ALARM_OUT = |lane_alarm;
    assign SUMMARY_ALARM_CONTRIB_OUT = SUMMARY_ALARM_OUT
                                       && !SUMMARY_ALARM_MASK_IN;

    // ------------------------------------------------------------
    // offset trim registers
    // ------------------------------------------------------------
    // fuse load wins over the calibration engine, which wins over
    // software; software is expected to stay off while calibrating
    trim_t core0_offset_value_reg;
    trim_t core1_offset_value_reg;
    trim_t core2_first_input_offset_value_reg;
    trim_t core2_second_input_offset_value_reg;
    trim_t core0_offset_value_next;
    trim_t core1_offset_value_next;
    trim_t core2a_next;
    trim_t core2b_next;
    wire logic cal_core0;
    wire logic cal_core1;
    wire logic cal_core2a;
    wire logic cal_core2b;
    wire trim_t sw_trim;

    assign cal_core0 = CAL_TRIM_WRITE_IN && CAL_TRIM_SEL_IN == CAL_SEL_CORE0;
    assign cal_core1 = CAL_TRIM_WRITE_IN && CAL_TRIM_SEL_IN == CAL_SEL_CORE1;
    assign cal_core2a = CAL_TRIM_WRITE_IN
                        && CAL_TRIM_SEL_IN == CAL_SEL_CORE2A;
    assign cal_core2b = CAL_TRIM_WRITE_IN
                        && CAL_TRIM_SEL_IN == CAL_SEL_CORE2B;
    assign sw_trim = WR_DATA_IN[TRIM_W-1:0];

    assign core0_offset_value_next =
        FUSE_LOAD_IN ? FUSE_CORE0_IN :
        cal_core0 ? CAL_TRIM_DATA_IN :
        wr_core0 ? sw_trim : core0_offset_value_reg;
    assign core1_offset_value_next =
        FUSE_LOAD_IN ? FUSE_CORE1_IN :
        cal_core1 ? CAL_TRIM_DATA_IN :
        wr_core1 ? sw_trim : core1_offset_value_reg;
    assign core2a_next =
        FUSE_LOAD_IN ? FUSE_CORE2A_IN :
        cal_core2a ? CAL_TRIM_DATA_IN :
        wr_core2a ? sw_trim : core2_first_input_offset_value_reg;
    assign core2b_next =
        FUSE_LOAD_IN ? FUSE_CORE2B_IN :
        cal_core2b ? CAL_TRIM_DATA_IN :
        wr_core2b ? sw_trim : core2_second_input_offset_value_reg;

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            core0_offset_value_reg <= TRIM_RESET;
            core1_offset_value_reg <= TRIM_RESET;
            core2_first_input_offset_value_reg <= TRIM_RESET;
            core2_second_input_offset_value_reg <= TRIM_RESET;
        end else begin
            core0_offset_value_reg <= core0_offset_value_next;
            core1_offset_value_reg <= core1_offset_value_next;
            core2_first_input_offset_value_reg <= core2a_next;
            core2_second_input_offset_value_reg <= core2b_next;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    wire logic [DATA_W-1:0] read_mux;
    logic [DATA_W-1:0] rd_data_reg;

    assign read_mux =
        hit_alarm ? DATA_W'(lane_alarm) :
        hit_core0 ? DATA_W'(core0_offset_value_reg) :
        hit_core1 ? DATA_W'(core1_offset_value_reg) :
        hit_core2a ? DATA_W'(core2_first_input_offset_value_reg) :
        hit_core2b ? DATA_W'(core2_second_input_offset_value_reg) :
        READ_IDLE;

    always_ff @(posedge CLK_SYS_IN) begin
        if (RESET_IN) begin
            rd_data_reg <= READ_IDLE;
        end else begin
            rd_data_reg <= RD_STROBE_IN ? read_mux : READ_IDLE;
        end
    end

    assign RD_DATA_OUT = rd_data_reg;

    // ------------------------------------------------------------
    // trim application per core
    // ------------------------------------------------------------
    core_sample_if #(.W(TRIM_W)) core0_bus (
        .clk(CLK_SYS_IN),
        .rst(RESET_IN)
    );
    core_sample_if #(.W(TRIM_W)) core1_bus (
        .clk(CLK_SYS_IN),
        .rst(RESET_IN)
    );
    core_sample_if #(.W(TRIM_W)) core2_bus (
        .clk(CLK_SYS_IN),
        .rst(RESET_IN)
    );

    assign core0_bus.sample = CORE0_SAMPLE_IN;
    assign core0_bus.sample_valid = CORE0_VALID_IN;
    assign core0_bus.trim = core0_offset_value_reg;
    assign core1_bus.sample = CORE1_SAMPLE_IN;
    assign core1_bus.sample_valid = CORE1_VALID_IN;
    assign core1_bus.trim = core1_offset_value_reg;
    assign core2_bus.sample = CORE2_SAMPLE_IN;
    assign core2_bus.sample_valid = CORE2_VALID_IN;
    assign core2_bus.trim = CORE2_SECOND_INPUT_IN ?
                            core2_second_input_offset_value_reg :
                            core2_first_input_offset_value_reg;

    offset_apply core0_apply (
        .port(core0_bus)
    );
    offset_apply core1_apply (
        .port(core1_bus)
    );
    offset_apply core2_apply (
        .port(core2_bus)
    );

    assign CORE0_RESULT_OUT = core0_bus.result;
    assign CORE0_RESULT_VALID_OUT = core0_bus.result_valid;
    assign CORE1_RESULT_OUT = core1_bus.result;
    assign CORE1_RESULT_VALID_OUT = core1_bus.result_valid;
    assign CORE2_RESULT_OUT = core2_bus.result;
    assign CORE2_RESULT_VALID_OUT = core2_bus.result_valid;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (RESET_IN);

    sequence s_summary_clear;
        SUMMARY_ALARM_CLEAR_IN && LANE_BUFFER_ERROR_IN == '0;
    endsequence
    sequence s_alarm_read_clean;
        RD_STROBE_IN && hit_alarm ##1 RD_DATA_OUT == '0;
    endsequence
    sequence s_trim_write;
        wr_core1 && !FUSE_LOAD_IN && !CAL_TRIM_WRITE_IN;
    endsequence

    a_summary_clears_all:
    assert property (s_summary_clear ##1 LANE_BUFFER_ERROR_IN == '0
                     |=> s_alarm_read_clean or !RD_STROBE_IN
                         or !hit_alarm)
        else $error("summary clear left lane alarms standing");
    a_summary_wipe_now:
    assert property (s_summary_clear |=> !SUMMARY_ALARM_OUT)
        else $error("summary clear did not wipe lane alarms");
    a_trim_write_store:
    assert property (s_trim_write ##1 (RD_STROBE_IN && hit_core1)
                     |=> RD_DATA_OUT == DATA_W'($past(sw_trim, 2)))
        else $error("core 1 trim write not read back");
    a_fuse_preload:
    assert property (FUSE_LOAD_IN
                     |=> core0_offset_value_reg == $past(FUSE_CORE0_IN)
                         && core2_second_input_offset_value_reg
                            == $past(FUSE_CORE2B_IN))
        else $error("fuse load did not reach trims");
    a_core2_second_trim:
    assert property (CORE2_VALID_IN && CORE2_SECOND_INPUT_IN
                     && CORE2_SAMPLE_IN
                        >= core2_second_input_offset_value_reg
                     |=> CORE2_RESULT_OUT
                         == $past(CORE2_SAMPLE_IN)
                            - $past(core2_second_input_offset_value_reg))
        else $error("core 2 second input used wrong trim");
    a_core2_first_trim:
    assert property (CORE2_VALID_IN && !CORE2_SECOND_INPUT_IN
                     && CORE2_SAMPLE_IN
                        >= core2_first_input_offset_value_reg
                     |=> CORE2_RESULT_OUT
                         == $past(CORE2_SAMPLE_IN)
                            - $past(core2_first_input_offset_value_reg))
        else $error("core 2 first input used wrong trim");
    a_mask_blocks_summary:
    assert property (SUMMARY_ALARM_MASK_IN |-> !SUMMARY_ALARM_CONTRIB_OUT)
        else $error("masked summary alarm escaped");
    a_read_one_cycle:
    assert property (!RD_STROBE_IN |=> RD_DATA_OUT == READ_IDLE)
        else $error("read data outside its cycle");
    a_cal_spare_trim:
    assert property (CAL_TRIM_WRITE_IN && !FUSE_LOAD_IN
                     && CAL_TRIM_SEL_IN == CAL_SEL_CORE2B
                     |=> core2_second_input_offset_value_reg
                         == $past(CAL_TRIM_DATA_IN))
        else $error("calibration trim not stored");
endmodule
`default_nettype wire

//--- verification/lane_alarm_offset_trim_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module lane_alarm_offset_trim_regs_tb
    import trim_regs_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic [DATA_W-1:0] rdata;
    logic wr = 1'b0;
    logic rd = 1'b0;
    lane_mask_t lane_err = LANE_NONE;
    logic sum_clr = 1'b0;
    logic sum_mask = 1'b0;
    logic sum_alarm;
    logic sum_contrib;
    logic fuse_load = 1'b0;
    trim_t fuse0 = 12'h000;
    trim_t fuse1 = 12'h000;
    trim_t fuse2a = 12'h000;
    trim_t fuse2b = 12'h000;
    logic cal_wr = 1'b0;
    logic [1:0] cal_sel = 2'h0;
    trim_t cal_data = 12'h000;
    trim_t smp0 = 12'h000;
    trim_t smp1 = 12'h000;
    trim_t smp2 = 12'h000;
    logic v0 = 1'b0;
    logic v1 = 1'b0;
    logic v2 = 1'b0;
    logic sec = 1'b0;
    trim_t res0;
    trim_t res1;
    trim_t res2;
    logic rv0;
    logic rv1;
    logic rv2;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    logic [ADDR_W-1:0] trim_addr [4] = '{CORE0_TRIM_ADDR, CORE1_TRIM_ADDR,
        CORE2A_TRIM_ADDR, CORE2B_TRIM_ADDR};

    always #4 clk = ~clk;

    lane_alarm_offset_trim_regs #(
        .LANES(LANE_COUNT)
    ) lane_alarm_offset_trim_regs_inst (
        .CLK_SYS_IN(clk),
        .RESET_IN(rst),
        .ADDR_IN(addr),
        .WR_DATA_IN(wdata),
        .WR_STROBE_IN(wr),
        .RD_STROBE_IN(rd),
        .RD_DATA_OUT(rdata),
        .LANE_BUFFER_ERROR_IN(lane_err),
        .SUMMARY_ALARM_CLEAR_IN(sum_clr),
        .SUMMARY_ALARM_MASK_IN(sum_mask),
        .SUMMARY_ALARM_OUT(sum_alarm),
        .SUMMARY_ALARM_CONTRIB_OUT(sum_contrib),
        .FUSE_LOAD_IN(fuse_load),
        .FUSE_CORE0_IN(fuse0),
        .FUSE_CORE1_IN(fuse1),
        .FUSE_CORE2A_IN(fuse2a),
        .FUSE_CORE2B_IN(fuse2b),
        .CAL_TRIM_WRITE_IN(cal_wr),
        .CAL_TRIM_SEL_IN(cal_sel),
        .CAL_TRIM_DATA_IN(cal_data),
        .CORE0_SAMPLE_IN(smp0),
        .CORE0_VALID_IN(v0),
        .CORE1_SAMPLE_IN(smp1),
        .CORE1_VALID_IN(v1),
        .CORE2_SAMPLE_IN(smp2),
        .CORE2_VALID_IN(v2),
        .CORE2_SECOND_INPUT_IN(sec),
        .CORE0_RESULT_OUT(res0),
        .CORE0_RESULT_VALID_OUT(rv0),
        .CORE1_RESULT_OUT(res1),
        .CORE1_RESULT_VALID_OUT(rv1),
        .CORE2_RESULT_OUT(res2),
        .CORE2_RESULT_VALID_OUT(rv2)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [15:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, e);
    endtask

    // write, then read back with no idle cycle between the strobes
    task automatic reg_wr_rd(input logic [ADDR_W-1:0] a,
                             input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, d);
    endtask

    task automatic lane_pulse(input lane_mask_t m);
        @(posedge clk);
        lane_err <= m;
        @(posedge clk);
        lane_err <= LANE_NONE;
    endtask

    task automatic run_sample(input int core, input trim_t s, input logic sb,
                              input trim_t e);
        @(posedge clk);
        sec <= sb;
        smp0 <= s;
        smp1 <= s;
        smp2 <= s;
        v0 <= (core == 0);
        v1 <= (core == 1);
        v2 <= (core == 2);
        @(posedge clk);
        v0 <= 1'b0;
        v1 <= 1'b0;
        v2 <= 1'b0;
        #1;
        check(16'(core == 0 ? res0 : core == 1 ? res1 : res2), 16'(e));
        // only the addressed core may flag a result
        check(16'({rv0, rv1, rv2}), 16'(3'b100 >> core));
    endtask

    // a hang is cut short well beyond the some 160 cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        reg_rd(LANE_ALARM_ADDR, 16'h00ff);
        check({15'h0, sum_alarm}, 16'h1);
        for (int i = 0; i < 4; i++) begin
            reg_rd(trim_addr[i], 16'h0000);
        end
        reg_rd(10'h2c6, 16'h0000);
        $display("test reset values done");

        reg_wr(LANE_ALARM_ADDR, 16'h000f);
        reg_rd(LANE_ALARM_ADDR, 16'h00f0);
        reg_wr(LANE_ALARM_ADDR, 16'h00f0);
        reg_rd(LANE_ALARM_ADDR, 16'h0000);
        check({15'h0, sum_alarm}, 16'h0);
        for (int i = 0; i < LANE_COUNT; i++) begin
            lane_pulse(lane_mask_t'(1 << i));
            reg_rd(LANE_ALARM_ADDR, 16'(1 << i));
            reg_wr(LANE_ALARM_ADDR, 16'(1 << i));
        end
        reg_rd(LANE_ALARM_ADDR, 16'h0000);
        $display("test lane set and clear done");

        // lanes 3 and 5 slip only in the cycle their alarms are cleared
        @(posedge clk);
        wr <= 1'b1;
        addr <= LANE_ALARM_ADDR;
        wdata <= 16'h00ff;
        lane_err <= 8'h28;
        @(posedge clk);
        wr <= 1'b0;
        lane_err <= LANE_NONE;
        reg_rd(LANE_ALARM_ADDR, 16'h0028);
        // lane 5 slip persists through the clearing write
        @(posedge clk);
        lane_err <= 8'h20;
        reg_wr(LANE_ALARM_ADDR, 16'h0028);
        reg_rd(LANE_ALARM_ADDR, 16'h0020);
        @(posedge clk);
        lane_err <= LANE_NONE;
        reg_wr(LANE_ALARM_ADDR, 16'h0020);
        reg_rd(LANE_ALARM_ADDR, 16'h0000);
        $display("test persisting slip done");

        lane_pulse(8'h81);
        @(posedge clk);
        sum_clr <= 1'b1;
        @(posedge clk);
        sum_clr <= 1'b0;
        reg_rd(LANE_ALARM_ADDR, 16'h0000);
        lane_pulse(8'h02);
        sum_mask <= 1'b1;
        @(posedge clk);
        #1 check({15'h0, sum_contrib}, 16'h0);
        check({15'h0, sum_alarm}, 16'h1);
        @(posedge clk);
        sum_mask <= 1'b0;
        @(posedge clk);
        #1 check({15'h0, sum_contrib}, 16'h1);
        $display("test summary clear and mask done");

        @(posedge clk);
        fuse0 <= 12'h5a1;
        fuse1 <= 12'h3c2;
        fuse2a <= 12'h0f3;
        fuse2b <= 12'hab4;
        fuse_load <= 1'b1;
        @(posedge clk);
        fuse_load <= 1'b0;
        // no calibration running, read at once
        reg_rd(CORE0_TRIM_ADDR, 16'h05a1);
        reg_rd(CORE1_TRIM_ADDR, 16'h03c2);
        reg_rd(CORE2A_TRIM_ADDR, 16'h00f3);
        reg_rd(CORE2B_TRIM_ADDR, 16'h0ab4);
        $display("test fuse load done");

        // trims touched only after calibration writes
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            cal_wr <= 1'b1;
            cal_sel <= 2'(i);
            cal_data <= 12'h700 + 12'(i);
            @(posedge clk);
            cal_wr <= 1'b0;
            reg_rd(trim_addr[i], 16'h0700 + 16'(i));
        end
        $display("test calibration writes done");

        reg_wr(CORE0_TRIM_ADDR, 16'h0010);
        reg_wr_rd(CORE1_TRIM_ADDR, 16'h0234);
        reg_wr(CORE2A_TRIM_ADDR, 16'h0011);
        reg_wr(CORE2B_TRIM_ADDR, 16'h0022);
        reg_rd(CORE0_TRIM_ADDR, 16'h0010);
        reg_rd(CORE2B_TRIM_ADDR, 16'h0022);
        run_sample(0, 12'h100, 1'b0, 12'h0f0);
        run_sample(0, 12'h005, 1'b0, 12'h000);
        run_sample(1, 12'h300, 1'b1, 12'h0cc);
        run_sample(2, 12'h100, 1'b0, 12'h0ef);
        run_sample(2, 12'h100, 1'b1, 12'h0de);
        run_sample(2, 12'hfff, 1'b0, 12'hfee);
        $display("test trim application done");
        end_sim();
    end
endmodule
`default_nettype wire
